// ### logic/status_irq_regs.vh
// Timing counts, source indices and mode codes for the status, interrupt and startup block.
`ifndef STATUS_IRQ_REGS_VH
`define STATUS_IRQ_REGS_VH
`define SRC_CLK0 0
`define SRC_CLK1 1
`define SRC_JPLL 2
`define SRC_SPLL 3
`define SRC_HOLD 4
`define SRC_REF 5
`define NUM_SRC 6
`define CLK_PERIOD_NS 8
`define INIT_TIME_NS 256
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_LOCK_RESTART_TIME_NS 64
`define PLL_LOCK_RESTART_CYCLES ((`PLL_LOCK_RESTART_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_MANUAL 2'h0
`define MODE_AUTO 2'h1
`define MODE_AUTO_HOLD 2'h2
`define MODE_SHORT_HOLD 2'h3
`endif

// ### logic/sticky_bit.v
// One latched status bit with write-one clear and interrupt gating.
`timescale 1ns/100ps
`default_nettype none
module sticky_bit (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Condition and software access.
    input wire fault,
    input wire clear_pulse,
    input wire irq_enable,
    // Results.
    output wire sticky_fault,
    output wire irq_request
);
    reg latch_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_reg <= 1'b0;
        end else if (fault) begin
            // A persisting fault wins over a clear in the same cycle.
            latch_reg <= 1'b1;
        end else if (clear_pulse) begin
            latch_reg <= 1'b0;
        end
    end
    assign sticky_fault = latch_reg;
    assign irq_request = latch_reg & irq_enable;
endmodule // sticky_bit
`default_nettype wire

// ### logic/status_irq_ctrl.v
// Status bits, latched faults, interrupt pin, lock pin and startup control.
`timescale 1ns/100ps
`default_nettype none
`include "status_irq_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Live status bits are read-only and follow their condition directly.
// - Latched bits set on fault and stay until software writes one.
// - Clear takes effect only once the condition is gone; else set again.
// - Each latched bit has an enable; zero masks it from interrupt.
// - Interrupt stays asserted until all enabled latched sources cleared.
// - Both PLL lock bits read one locked, zero on loss of lock.
// - Selection bit reads zero for input 0, one for input 1.
// - Manual and short holdover: reference bit zero when selected input lost.
// - Automatic: reference bit zero while lost or selecting; one once chosen.
// - Automatic with holdover: reference bit zero while lost and in holdover.
// - Lock pin one only when both PLLs locked.
// - Reset returns all bits to defaults; clock outputs disabled.
// - VCXO voltage forced to mid-supply until software clears force bit.
// - Divider init bit starts divider sync, then clears itself.
// - Bank clock outputs held low during divider initialisation, from one cycle after it starts to one cycle after it ends.
// - Pll_lock_restart and calibration bits clear themselves after being set.
module status_irq_ctrl (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Raw conditions from monitors, asynchronous to ref_clk.
    input wire input0_active_in,
    input wire input1_active_in,
    input wire jitter_pll_locked_in,
    input wire synth_pll_locked_in,
    input wire holdover_active_in,
    input wire selected_input_in,
    input wire selection_busy_in,
    input wire vco_cal_complete_in,
    // Configuration.
    input wire [1:0] switch_mode,
    input wire input0_irq_mask_on,
    input wire input1_irq_mask_on,
    input wire jitter_pll_irq_on,
    input wire synth_pll_irq_on,
    input wire holdover_irq_on,
    input wire reference_irq_on,
    input wire [5:0] sticky_clear,
    input wire vcxo_hold_clear,
    input wire init_request,
    input wire pll_lock_restart_request,
    input wire calibrate_request,
    input wire [11:0] outputs_enable,
    input wire [11:0] bank_clocks_raw,
    // Live status.
    output reg input0_live_state,
    output reg input1_live_state,
    output reg jitter_pll_lock_live_n,
    output reg synth_pll_lock_live_n,
    output reg holdover_live_n,
    output reg active_input_indicator,
    output reg reference_valid_live,
    output reg vco_calibration_done,
    // Latched status.
    output wire input0_sticky_state,
    output wire input1_sticky_state,
    output wire jitter_pll_lock_sticky_n,
    output wire synth_pll_lock_sticky_n,
    output wire holdover_sticky_n,
    output wire reference_valid_sticky,
    // Pins and control.
    output wire irq_out_n,
    output reg lock_out,
    output reg vcxo_voltage_hold,
    output reg vcxo_control_pin,
    output reg divider_init_busy,
    output reg divider_sync_pulse,
    output reg pll_lock_restart,
    output reg vco_band_calibrate,
    output reg [11:0] bank_clock_outputs
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers; first stage is read only by the second stage.
    reg [7:0] sync1_reg;
    reg [7:0] sync2_reg;
    wire [7:0] raw_in = {vco_cal_complete_in, selection_busy_in, selected_input_in, holdover_active_in,
                         synth_pll_locked_in, jitter_pll_locked_in, input1_active_in, input0_active_in};
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire in0_ok = sync2_reg[0];
    wire in1_ok = sync2_reg[1];
    wire jpll_ok = sync2_reg[2];
    wire spll_ok = sync2_reg[3];
    wire hold_on = sync2_reg[4];
    wire sel_in = sync2_reg[5];
    wire sel_busy = sync2_reg[6];
    wire cal_done = sync2_reg[7];
    ////////////////////////////////////////////////////////////////////////////
    // Reference validity by switching mode.
    reg ref_valid;
    wire sel_lost = sel_in ? ~in1_ok : ~in0_ok;
    always @* begin
        case (switch_mode)
            `MODE_MANUAL: ref_valid = ~sel_lost;
            `MODE_SHORT_HOLD: ref_valid = ~sel_lost;
            `MODE_AUTO: ref_valid = ~sel_lost & ~sel_busy;
            `MODE_AUTO_HOLD: ref_valid = ~(sel_lost & hold_on);
            default: ref_valid = ~sel_lost;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // Live status registers.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            input0_live_state <= 1'b0;
            input1_live_state <= 1'b0;
            jitter_pll_lock_live_n <= 1'b0;
            synth_pll_lock_live_n <= 1'b0;
            holdover_live_n <= 1'b1;
            active_input_indicator <= 1'b0;
            reference_valid_live <= 1'b0;
            vco_calibration_done <= 1'b0;
            lock_out <= 1'b0;
        end else begin
            input0_live_state <= in0_ok;
            input1_live_state <= in1_ok;
            jitter_pll_lock_live_n <= jpll_ok;
            synth_pll_lock_live_n <= spll_ok;
            holdover_live_n <= ~hold_on;
            active_input_indicator <= sel_in;
            reference_valid_live <= ref_valid;
            vco_calibration_done <= cal_done;
            lock_out <= jpll_ok & spll_ok;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Latched faults; a sticky bit holds the fault, the port shows it inverted.
    wire [5:0] fault_vec;
    wire [5:0] enable_vec;
    wire [5:0] sticky_vec;
    wire [5:0] irq_vec;
    assign fault_vec[`SRC_CLK0] = ~input0_live_state;
    assign fault_vec[`SRC_CLK1] = ~input1_live_state;
    assign fault_vec[`SRC_JPLL] = ~jitter_pll_lock_live_n;
    assign fault_vec[`SRC_SPLL] = ~synth_pll_lock_live_n;
    assign fault_vec[`SRC_HOLD] = ~holdover_live_n;
    assign fault_vec[`SRC_REF] = ~reference_valid_live;
    assign enable_vec = {reference_irq_on, holdover_irq_on, synth_pll_irq_on,
                         jitter_pll_irq_on, input1_irq_mask_on, input0_irq_mask_on};
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SRC; gi = gi + 1) begin : g_sticky
            sticky_bit u_bit (
                .ref_clk(ref_clk),
                .rst(rst),
                .fault(fault_vec[gi]),
                .clear_pulse(sticky_clear[gi]),
                .irq_enable(enable_vec[gi]),
                .sticky_fault(sticky_vec[gi]),
                .irq_request(irq_vec[gi])
            );
        end
    endgenerate
    assign input0_sticky_state = ~sticky_vec[`SRC_CLK0];
    assign input1_sticky_state = ~sticky_vec[`SRC_CLK1];
    assign jitter_pll_lock_sticky_n = ~sticky_vec[`SRC_JPLL];
    assign synth_pll_lock_sticky_n = ~sticky_vec[`SRC_SPLL];
    assign holdover_sticky_n = ~sticky_vec[`SRC_HOLD];
    assign reference_valid_sticky = ~sticky_vec[`SRC_REF];
    // Pin is released only when no enabled latched source remains.
    assign irq_out_n = ~(|irq_vec);
    ////////////////////////////////////////////////////////////////////////////
    // Startup and resynchronisation control.
    // Counter loads, cut on purpose to the counter width.
    localparam [31:0] INIT_LOAD_FULL = `INIT_CYCLES - 1;
    localparam [31:0] PLL_LOCK_RESTART_LOAD_FULL = `PLL_LOCK_RESTART_CYCLES;
    reg [7:0] init_cnt_reg;
    reg [7:0] pll_lock_restart_cnt_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vcxo_voltage_hold <= 1'b1;
            vcxo_control_pin <= 1'b1;
            divider_init_busy <= 1'b0;
            divider_sync_pulse <= 1'b0;
            init_cnt_reg <= 8'h00;
            pll_lock_restart_cnt_reg <= 8'h00;
            pll_lock_restart <= 1'b0;
            vco_band_calibrate <= 1'b0;
            bank_clock_outputs <= 12'h000;
        end else begin
            // Forcing stays until software clears it; it is not re-armed.
            if (vcxo_hold_clear) begin
                vcxo_voltage_hold <= 1'b0;
            end
            vcxo_control_pin <= vcxo_voltage_hold;
            divider_sync_pulse <= 1'b0;
            if (init_request && !divider_init_busy) begin
                divider_init_busy <= 1'b1;
                divider_sync_pulse <= 1'b1;
                init_cnt_reg <= INIT_LOAD_FULL[7:0];
            end else if (divider_init_busy) begin
                if (init_cnt_reg == 8'h00) begin
                    divider_init_busy <= 1'b0;
                end else begin
                    init_cnt_reg <= init_cnt_reg - 8'h01;
                end
            end
            // Pll_lock_restart stays separate from init; a request during init is dropped, not queued.
            if ((pll_lock_restart_request || calibrate_request) && pll_lock_restart_cnt_reg == 8'h00 && !divider_init_busy) begin
                pll_lock_restart <= pll_lock_restart_request;
                vco_band_calibrate <= calibrate_request;
                pll_lock_restart_cnt_reg <= PLL_LOCK_RESTART_LOAD_FULL[7:0];
            end else if (pll_lock_restart_cnt_reg != 8'h00) begin
                pll_lock_restart_cnt_reg <= pll_lock_restart_cnt_reg - 8'h01;
                if (pll_lock_restart_cnt_reg == 8'h01) begin
                    pll_lock_restart <= 1'b0;
                    vco_band_calibrate <= 1'b0;
                end
            end
            if (divider_init_busy) begin
                bank_clock_outputs <= 12'h000;
            end else begin
                bank_clock_outputs <= bank_clocks_raw & outputs_enable;
            end
        end
    end
endmodule // status_irq_ctrl
`default_nettype wire

// ### tb/status_irq_ctrl_sva.sv
// Assertions on the ports of the status, interrupt and startup block.
`timescale 1ns/100ps
`default_nettype none
module status_irq_ctrl_sva (
    // Clock, reset, requests and bank clock outputs.
    input wire ref_clk, input wire rst, input wire [5:0] sticky_clear, input wire vcxo_hold_clear,
    input wire init_request, input wire pll_lock_restart_request, input wire [11:0] bank_clock_outputs,
    // Status and pins.
    input wire input1_sticky_state, input wire jitter_pll_lock_sticky_n, input wire synth_pll_lock_sticky_n,
    input wire holdover_sticky_n, input wire jitter_pll_lock_live_n, input wire synth_pll_lock_live_n,
    input wire holdover_live_n, input wire lock_out, input wire vcxo_voltage_hold, input wire vcxo_control_pin,
    input wire divider_init_busy, input wire divider_sync_pulse, input wire pll_lock_restart,
    input wire vco_band_calibrate
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire both_locked = jitter_pll_lock_live_n && synth_pll_lock_live_n;
    sequence init_go; init_request && !divider_init_busy; endsequence
    sequence init_run; divider_sync_pulse && divider_init_busy ##1 !divider_sync_pulse; endsequence
    sequence init_span; ##31 divider_init_busy ##[1:2] !divider_init_busy; endsequence
    // A request is dropped while either pulse or the divider start is still running.
    sequence pll_lock_restart_go; pll_lock_restart_request && !pll_lock_restart && !vco_band_calibrate && !divider_init_busy; endsequence
    ////////////////////////////////////////////////////////////////////////////////
    hold_set_a: assert property (!holdover_live_n |=> !holdover_sticky_n)
        else $error("holdover not latched");
    pll_set_a: assert property (!jitter_pll_lock_live_n |=> !jitter_pll_lock_sticky_n)
        else $error("lock loss not latched");
    sticky_keep_a: assert property (!input1_sticky_state && !sticky_clear[1] |=> !input1_sticky_state)
        else $error("sticky bit lost");
    clear_ok_a: assert property (sticky_clear[3] && synth_pll_lock_live_n |=> synth_pll_lock_sticky_n)
        else $error("clear ignored");
    lock_pin_a: assert property ($stable(both_locked) [*3] |-> lock_out == both_locked)
        else $error("lock pin wrong");
    init_sync_a: assert property (init_go |=> init_run)
        else $error("init start wrong");
    init_len_a: assert property ($rose(divider_init_busy) |-> init_span)
        else $error("init length wrong");
    init_low_a: assert property (divider_init_busy && $past(divider_init_busy) |-> !(|bank_clock_outputs))
        else $error("outputs not low");
    pll_lock_restart_a: assert property (pll_lock_restart_go |=> pll_lock_restart [*8] ##1 !pll_lock_restart)
        else $error("pll_lock_restart length wrong");
    vcxo_a: assert property (vcxo_hold_clear |=> !vcxo_voltage_hold ##1 !vcxo_control_pin)
        else $error("vcxo release wrong");
endmodule // status_irq_ctrl_sva

bind status_irq_ctrl status_irq_ctrl_sva checker_i (.*);
`default_nettype wire

// ### tb/status_irq_ctrl_tb.sv
// Self-checking bench for the status, interrupt and startup block.
`timescale 1ns/100ps
`default_nettype none
`include "status_irq_regs.vh"
module status_irq_ctrl_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic vcxo_hold_clear, init_request, pll_lock_restart_request, calibrate_request;
    logic [1:0] switch_mode;
    logic [5:0] en, sticky_clear, sm, c;
    logic [7:0] cond, e;
    logic [11:0] outputs_enable, bank_clocks_raw;
    logic [31:0] seed = 32'hfe3c962d;
    int failures = 0;
    int samples_checked = 0;
    int i, n;
    wire input0_active_in, input1_active_in, jitter_pll_locked_in, synth_pll_locked_in, holdover_active_in;
    wire selected_input_in, selection_busy_in, vco_cal_complete_in, input0_irq_mask_on, input1_irq_mask_on;
    wire jitter_pll_irq_on, synth_pll_irq_on, holdover_irq_on, reference_irq_on, input0_live_state;
    wire input1_live_state, jitter_pll_lock_live_n, synth_pll_lock_live_n, holdover_live_n, lock_out;
    wire active_input_indicator, reference_valid_live, vco_calibration_done, input0_sticky_state;
    wire input1_sticky_state, jitter_pll_lock_sticky_n, synth_pll_lock_sticky_n, holdover_sticky_n;
    wire reference_valid_sticky, irq_out_n, vcxo_voltage_hold, vcxo_control_pin, divider_init_busy;
    wire divider_sync_pulse, pll_lock_restart, vco_band_calibrate;
    wire [11:0] bank_clock_outputs;
    assign {vco_cal_complete_in, selection_busy_in, selected_input_in, holdover_active_in, synth_pll_locked_in,
        jitter_pll_locked_in, input1_active_in, input0_active_in} = cond;
    assign {reference_irq_on, holdover_irq_on, synth_pll_irq_on, jitter_pll_irq_on, input1_irq_mask_on,
        input0_irq_mask_on} = en;
    wire [5:0] ok = {reference_valid_sticky, holdover_sticky_n, synth_pll_lock_sticky_n, jitter_pll_lock_sticky_n,
        input1_sticky_state, input0_sticky_state};
    wire [7:0] live = {vco_calibration_done, active_input_indicator, reference_valid_live, holdover_live_n,
        synth_pll_lock_live_n, jitter_pll_lock_live_n, input1_live_state, input0_live_state};
    status_irq_ctrl uut (.*);
    always #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // The reference bit depends on the switching mode; manual and short holdover share one meaning.
    function automatic logic [7:0] exp_live(input logic [7:0] v, input logic [1:0] m);
        logic p;
        p = v[5] ? v[1] : v[0];
        if (m == `MODE_AUTO) p = p && !v[6];
        else if (m == `MODE_AUTO_HOLD) p = p || !v[4];
        return {v[7], v[5], p, !v[4], v[3:0]};
    endfunction
    task chk(input logic [23:0] got, input logic [23:0] want);
        samples_checked++;
        if (got !== want) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task finish_test;
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {cond, en, sticky_clear, switch_mode, outputs_enable, bank_clocks_raw} = '0;
        {vcxo_hold_clear, init_request, pll_lock_restart_request, calibrate_request} = '0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk({irq_out_n, vcxo_voltage_hold, vcxo_control_pin, lock_out, ok, bank_clock_outputs}, 24'h3bf000);
        @(posedge ref_clk);
        rst <= 1'b0;
        sm = 6'h10;
        // Dividers first, then pll_lock_restart in its own write, then the VCXO release.
        @(posedge ref_clk);
        {init_request, outputs_enable, bank_clocks_raw} <= {1'b1, 24'hffffff};
        @(posedge ref_clk);
        init_request <= 1'b0;
        @(posedge ref_clk);
        // Corner case: requests that arrive while the dividers start are dropped.
        {init_request, pll_lock_restart_request} <= 2'h3;
        @(posedge ref_clk);
        {init_request, pll_lock_restart_request} <= 2'h0;
        #1;
        chk({divider_init_busy, pll_lock_restart, bank_clock_outputs}, 24'h002000);
        for (n = 3; divider_init_busy && n < 99; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 99) begin
            failures++;
            finish_test;
        end
        chk(n[23:0], 24'(`INIT_CYCLES + 1));
        @(posedge ref_clk);
        {pll_lock_restart_request, calibrate_request} <= 2'h3;
        @(posedge ref_clk);
        {pll_lock_restart_request, calibrate_request} <= 2'h0;
        #1;
        chk({pll_lock_restart, vco_band_calibrate}, 24'h3);
        repeat (7) @(posedge ref_clk);
        pll_lock_restart_request <= 1'b1;
        @(posedge ref_clk);
        pll_lock_restart_request <= 1'b0;
        #1;
        chk({pll_lock_restart, vco_band_calibrate}, 24'h0);
        @(posedge ref_clk);
        vcxo_hold_clear <= 1'b1;
        #1;
        chk(pll_lock_restart, 24'h0);
        @(posedge ref_clk);
        vcxo_hold_clear <= 1'b0;
        #1;
        chk(vcxo_voltage_hold, 24'h0);
        @(posedge ref_clk);
        #1;
        chk(vcxo_control_pin, 24'h0);
        for (i = 0; i < 40; i++) begin
            seed = xs(seed);
            // Mode is not synchronised, so it meets the old inputs for two cycles first.
            e = exp_live(cond, i[1:0]);
            sm = sm & e[5:0];
            @(posedge ref_clk);
            cond <= (i % 5 == 4) ? 8'h0f : seed[7:0];
            {switch_mode, en, outputs_enable, bank_clocks_raw} <= {i[1:0], seed[13:8], seed[31:8]};
            repeat (5) @(posedge ref_clk);
            #1;
            e = exp_live(cond, switch_mode);
            sm = sm & e[5:0];
            chk(live, e);
            chk(lock_out, e[2] & e[3]);
            chk({ok, irq_out_n}, {sm, ~|(~sm & en)});
            chk(bank_clock_outputs, outputs_enable & bank_clocks_raw);
            c = (i % 5 == 4) ? 6'h3f : seed[5:0] ^ seed[19:14];
            @(posedge ref_clk);
            sticky_clear <= c;
            @(posedge ref_clk);
            sticky_clear <= 6'h00;
            repeat (2) @(posedge ref_clk);
            #1;
            sm = sm | (c & e[5:0]);
            chk({ok, irq_out_n}, {sm, ~|(~sm & en)});
        end
        // Divider change: outputs off, divider start, pll_lock_restart in its own write, outputs back on.
        // The 12-bit outputs_enable passes straight through this block, so no transfer step is used.
        @(posedge ref_clk);
        {init_request, outputs_enable, bank_clocks_raw} <= {1'b1, 12'h000, 12'hfff};
        @(posedge ref_clk);
        init_request <= 1'b0;
        #1;
        chk({divider_init_busy, divider_sync_pulse, bank_clock_outputs}, 24'h003000);
        for (n = 0; divider_init_busy && n < 99; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 99) begin
            failures++;
            finish_test;
        end
        chk(n[23:0], 24'(`INIT_CYCLES));
        @(posedge ref_clk);
        pll_lock_restart_request <= 1'b1;
        @(posedge ref_clk);
        {pll_lock_restart_request, outputs_enable} <= {1'b0, 12'hfff};
        #1;
        chk({pll_lock_restart, vco_band_calibrate}, 24'h2);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(bank_clock_outputs, 24'hfff);
        finish_test;
    end
endmodule // status_irq_ctrl_tb
`default_nettype wire
